// [fcg_clock_generator.sv]
/*
 * Clock generator with frequency-locked loop, modelled on one 100 MHz clock.
 * Oscillators are phase accumulators; clock outputs other than the registered external reference copy are toggling flip-flops.
 * Assumes the oscillator pin input is synchronous and a register port with
 * read data returned in the cycle after the read strobe.
 */
// How it works
// - reset enters self-clocked mode, loop open
// - off mode freezes main output clock
// - internal loop mode multiplies internal reference
// - unlocked internal loop keeps adjusting oscillator
// - status shows lock and loss of lock
// - bypass mode drives output from external clock
// - external loop mode multiplies, unlocked then locked
// - first write reserves input pin for external
// - first write reserves output pin for external
// - high gain bit selects oscillator amplitude
// - range bit selects low or high crystal
// - internal 8 MHz debug and trimmable reference
// - loop output scaled for bus rates
// - post divider powers of two, 1 to 128
// - clock or lock loss requests reset or interrupt
// - external reference monitored, valid bit shown
// - oscillator keeps setting through stop, lost reference
// - non-running sources are locked out
// - output moves to loop clock once locked
// - separate self-clocked source for periodic timer
// - fixed-frequency enable beside multiplied and reference
// - mode field 00 self,01 int,10 byp,11 ext
// - bypass takes effect only when reference valid
// - internal first write bars later external modes
// - write-once bits take only first write
`timescale 1ns/1ps
`default_nettype none
`include "fcg_cfg.svh"

module fcg_clock_generator
    import fcg_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic stop_i,
    input wire logic osc_input_pin_i,
    output logic [7:0] rdata_o,
    output logic main_output_clock_o,
    output logic loop_multiplied_clock_o,
    output logic ext_reference_clock_o,
    output logic fixed_freq_enable_o,
    output logic debug_local_clock_o,
    output logic rti_clock_o,
    output logic osc_input_pin_en_o,
    output logic osc_output_pin_o,
    output logic osc_output_pin_oe_o,
    output logic osc_high_gain_o,
    output logic osc_range_o,
    output logic reset_req_o,
    output logic irq_req_o
);
    localparam logic [15:0] IRC_STEP = 16'((`FCG_IRC_HZ * `FCG_ACC_ONE) / `FCG_CLK_HZ);
    // toggle flops flip once per overflow, so these steps run at twice the clock rate
    localparam logic [15:0] DBG_STEP = 16'((64'd2 * `FCG_DBG_HZ * `FCG_ACC_ONE) / `FCG_CLK_HZ);
    localparam logic [15:0] RTI_STEP = 16'((64'd2 * `FCG_RTI_HZ * `FCG_ACC_ONE) / `FCG_CLK_HZ);
    localparam logic [11:0] LOC_CYC = 12'(`FCG_LOC_CYC);

    typedef struct packed {
        fcg_mode_e mode;
        fcg_ctrl1_s c1;
        fcg_ctrl2_s c2;
        logic c1_written;
        logic ext_rsv;
        logic [11:0] filter_value;
        logic [7:0] trim;
        logic lock;
        logic lost_lock;
        logic lost_clk;
        logic ext_ref_clock_status;
        logic generator_irq_flag;
        logic [15:0] osc_acc;
        logic [15:0] irc_acc;
        logic [15:0] dbg_acc;
        logic [15:0] rti_acc;
        logic [7:0] osc_cnt;
        logic ext_prev;
        logic [2:0] ext_edges;
        logic [11:0] loc_cnt;
        logic src_ext;
        logic [6:0] div_cnt;
        logic main_clk;
        logic osc_clk;
        logic dbg_clk;
        logic rti_clk;
        logic ext_clk;
        logic ffe;
        logic pin_en;
        logic pin_out;
        logic pin_oe;
        logic reset_req;
        logic irq_req;
        logic [7:0] rdata;
    } fcg_state_s;

    fcg_state_s st_ff;
    fcg_state_s nxt_st;
    fcg_bus_s bus;

    assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    always_comb begin
        logic [16:0] osc_sum;
        logic [16:0] irc_sum;
        logic [16:0] dbg_sum;
        logic [16:0] rti_sum;
        logic osc_tick;
        logic irc_tick;
        logic ext_rise;
        logic ref_tick;
        logic loop_on;
        logic [7:0] target;
        logic [7:0] diff;
        logic src_tick;
        logic want_ext;
        logic osc_run;
        logic loc_event;
        logic lol_event;
        logic [6:0] div_top;
        fcg_mode_e req;
        nxt_st = st_ff;
        osc_sum = '0;
        irc_sum = '0;
        dbg_sum = '0;
        rti_sum = '0;
        osc_tick = 1'b0;
        irc_tick = 1'b0;
        ext_rise = 1'b0;
        ref_tick = 1'b0;
        loop_on = 1'b0;
        target = '0;
        diff = '0;
        src_tick = 1'b0;
        want_ext = 1'b0;
        osc_run = 1'b0;
        loc_event = 1'b0;
        lol_event = 1'b0;
        div_top = '0;
        req = st_ff.mode;

        // oscillators as phase accumulators
        osc_sum = {1'b0, st_ff.osc_acc} + {5'h00, st_ff.filter_value};
        osc_tick = osc_sum[16];
        nxt_st.osc_acc = osc_sum[15:0];
        irc_sum = {1'b0, st_ff.irc_acc} + {1'b0, IRC_STEP} + {9'h000, st_ff.trim}
            - {1'b0, `FCG_TRIM_MID};
        irc_tick = irc_sum[16];
        nxt_st.irc_acc = irc_sum[15:0];
        dbg_sum = {1'b0, st_ff.dbg_acc} + {1'b0, DBG_STEP};
        nxt_st.dbg_acc = dbg_sum[15:0];
        if (dbg_sum[16]) begin
            nxt_st.dbg_clk = ~st_ff.dbg_clk;
        end
        rti_sum = {1'b0, st_ff.rti_acc} + {1'b0, RTI_STEP};
        nxt_st.rti_acc = rti_sum[15:0];
        if (rti_sum[16]) begin
            nxt_st.rti_clk = ~st_ff.rti_clk;
        end
        if (osc_tick) begin
            nxt_st.osc_clk = ~st_ff.osc_clk;
        end

        // oscillator pins
        osc_run = st_ff.ext_rsv && (st_ff.mode != MODE_OFF || st_ff.c1.osc_keep_on_in_off);
        nxt_st.pin_en = st_ff.ext_rsv;
        nxt_st.pin_oe = osc_run && st_ff.c1.ext_reference_select;
        nxt_st.pin_out = ~osc_input_pin_i;
        nxt_st.ext_clk = osc_run && osc_input_pin_i;

        // reference monitor
        nxt_st.ext_prev = osc_input_pin_i;
        ext_rise = osc_run && osc_input_pin_i && !st_ff.ext_prev;
        if (!osc_run) begin
            nxt_st.ext_edges = '0;
            nxt_st.loc_cnt = '0;
            nxt_st.ext_ref_clock_status = 1'b0;
        end else if (ext_rise) begin
            nxt_st.loc_cnt = '0;
            if (st_ff.ext_edges != `FCG_EDGES_VALID) begin
                nxt_st.ext_edges = st_ff.ext_edges + 3'h1;
            end else begin
                nxt_st.ext_ref_clock_status = 1'b1;
            end
        end else if (st_ff.loc_cnt != LOC_CYC) begin
            nxt_st.loc_cnt = st_ff.loc_cnt + 12'h001;
        end else begin
            nxt_st.ext_edges = '0;
            nxt_st.ext_ref_clock_status = 1'b0;
            loc_event = st_ff.ext_ref_clock_status && !st_ff.c1.clock_loss_detect_disable;
        end

        // mode selection
        case (st_ff.c1.clock_mode_field)
            2'b00: req = MODE_SELF;
            2'b01: req = MODE_LOOP_INT;
            2'b10: req = st_ff.ext_ref_clock_status ? MODE_BYP_EXT : st_ff.mode;
            2'b11: req = st_ff.ext_ref_clock_status ? MODE_LOOP_EXT : st_ff.mode;
            default: req = MODE_SELF;
        endcase
        if (req == MODE_OFF) begin
            req = MODE_SELF;
        end
        if (stop_i) begin
            nxt_st.mode = MODE_OFF;
        end else if (loc_event || ((req == MODE_BYP_EXT || req == MODE_LOOP_EXT)
                && !st_ff.ext_ref_clock_status)) begin
            nxt_st.mode = MODE_SELF;
        end else begin
            nxt_st.mode = req;
        end

        // frequency-locked loop
        case (st_ff.mode)
            MODE_LOOP_INT: begin
                loop_on = 1'b1;
                ref_tick = irc_tick;
            end
            MODE_LOOP_EXT: begin
                loop_on = st_ff.ext_ref_clock_status;
                ref_tick = ext_rise;
            end
            default: begin
                loop_on = 1'b0;
                ref_tick = 1'b0;
            end
        endcase
        target = {4'h0, st_ff.c2.mult_factor, 1'b0} + 8'h04;
        diff = (st_ff.osc_cnt > target) ? st_ff.osc_cnt - target : target - st_ff.osc_cnt;
        if (!loop_on) begin
            if (st_ff.mode != MODE_LOOP_EXT) begin
                nxt_st.lock = 1'b0;
            end
            nxt_st.osc_cnt = '0;
        end else if (ref_tick) begin
            nxt_st.osc_cnt = {7'h00, osc_tick};
            if (st_ff.osc_cnt < target && st_ff.filter_value != 12'hFFF) begin
                nxt_st.filter_value = st_ff.filter_value + 12'h001;
            end else if (st_ff.osc_cnt > target && st_ff.filter_value != 12'h001) begin
                nxt_st.filter_value = st_ff.filter_value - 12'h001;
            end
            if (diff <= `FCG_LOCK_TOL) begin
                nxt_st.lock = 1'b1;
            end else if (st_ff.lock && diff > `FCG_UNLOCK_TOL) begin
                nxt_st.lock = 1'b0;
                lol_event = 1'b1;
            end
        end else if (osc_tick && st_ff.osc_cnt != 8'hFF) begin
            nxt_st.osc_cnt = st_ff.osc_cnt + 8'h01;
        end

        // glitch-free source switch and post divider
        want_ext = st_ff.mode == MODE_BYP_EXT;
        if ((st_ff.mode == MODE_LOOP_INT || st_ff.mode == MODE_LOOP_EXT) && !st_ff.lock) begin
            want_ext = st_ff.src_ext;
        end
        src_tick = st_ff.src_ext ? ext_rise : osc_tick;
        div_top = 7'((8'h01 << st_ff.c2.reduce_div) - 8'h01);
        if (!st_ff.main_clk && want_ext != st_ff.src_ext) begin
            nxt_st.src_ext = want_ext;
            nxt_st.div_cnt = '0;
        end else if (st_ff.mode != MODE_OFF && st_ff.src_ext && !st_ff.ext_ref_clock_status) begin
            // dead external source: end the stretched high phase so the switch can follow
            nxt_st.main_clk = 1'b0;
        end else if (st_ff.mode != MODE_OFF && src_tick) begin
            if (st_ff.div_cnt >= div_top) begin
                nxt_st.div_cnt = '0;
                nxt_st.main_clk = ~st_ff.main_clk;
            end else begin
                nxt_st.div_cnt = st_ff.div_cnt + 7'h01;
            end
        end
        nxt_st.ffe = st_ff.ext_ref_clock_status
            && (st_ff.mode == MODE_BYP_EXT || st_ff.mode == MODE_LOOP_EXT);

        // loss events, set wins over clear
        if (bus.wr && bus.addr == `FCG_REG_STAT1 && bus.wdata[`FCG_S1_FLAG]) begin
            nxt_st.generator_irq_flag = 1'b0;
            nxt_st.lost_lock = 1'b0;
            nxt_st.lost_clk = 1'b0;
        end
        if (lol_event) begin
            nxt_st.lost_lock = 1'b1;
        end
        if (loc_event) begin
            nxt_st.lost_clk = 1'b1;
        end
        nxt_st.reset_req = (lol_event && st_ff.c2.lol_reset_en)
            || (loc_event && st_ff.c2.loc_reset_en);
        if ((lol_event && !st_ff.c2.lol_reset_en) || (loc_event && !st_ff.c2.loc_reset_en)) begin
            nxt_st.generator_irq_flag = 1'b1;
        end
        nxt_st.irq_req = nxt_st.generator_irq_flag;

        // register writes
        if (bus.wr) begin
            case (bus.addr)
                `FCG_REG_CTRL1: begin
                    if (!st_ff.c1_written) begin
                        nxt_st.c1_written = 1'b1;
                        nxt_st.c1.high_gain_select = bus.wdata[`FCG_C1_HIGH_GAIN];
                        nxt_st.c1.range = bus.wdata[`FCG_C1_RANGE];
                        nxt_st.c1.ext_reference_select = bus.wdata[`FCG_C1_REF_SEL];
                        nxt_st.ext_rsv = bus.wdata[`FCG_C1_MODE_HI];
                    end
                    if (bus.wdata[`FCG_C1_MODE_HI] == 1'b0
                            || (st_ff.c1_written ? st_ff.ext_rsv : 1'b1)) begin
                        nxt_st.c1.clock_mode_field =
                            bus.wdata[`FCG_C1_MODE_HI:`FCG_C1_MODE_LO];
                    end
                    nxt_st.c1.osc_keep_on_in_off = bus.wdata[`FCG_C1_OSC_KEEP];
                    nxt_st.c1.clock_loss_detect_disable = bus.wdata[`FCG_C1_LOC_DIS];
                end
                `FCG_REG_CTRL2: nxt_st.c2 = bus.wdata;
                `FCG_REG_FILT_UP: begin
                    if (st_ff.mode == MODE_SELF) begin
                        nxt_st.filter_value[11:8] = bus.wdata[3:0];
                    end
                end
                `FCG_REG_FILT_LO: begin
                    if (st_ff.mode == MODE_SELF) begin
                        nxt_st.filter_value[7:0] = bus.wdata;
                    end
                end
                `FCG_REG_TRIM: nxt_st.trim = bus.wdata;
                default: nxt_st.trim = st_ff.trim;
            endcase
        end

        // register reads, data valid in the following cycle
        nxt_st.rdata = '0;
        if (bus.rd) begin
            case (bus.addr)
                `FCG_REG_CTRL1: nxt_st.rdata = {st_ff.c1, 1'b0};
                `FCG_REG_CTRL2: nxt_st.rdata = st_ff.c2;
                `FCG_REG_STAT1: nxt_st.rdata = {st_ff.src_ext ? 2'b10
                    : {st_ff.mode == MODE_LOOP_EXT,
                    st_ff.mode == MODE_LOOP_INT || st_ff.mode == MODE_LOOP_EXT},
                    st_ff.c1.ext_reference_select, st_ff.lost_lock, st_ff.lock,
                    st_ff.lost_clk, st_ff.ext_ref_clock_status, st_ff.generator_irq_flag};
                `FCG_REG_STAT2: nxt_st.rdata = {7'h00, st_ff.mode == MODE_LOOP_INT
                    || st_ff.mode == MODE_LOOP_EXT || st_ff.mode == MODE_SELF};
                `FCG_REG_FILT_UP: nxt_st.rdata = {4'h0, st_ff.filter_value[11:8]};
                `FCG_REG_FILT_LO: nxt_st.rdata = st_ff.filter_value[7:0];
                `FCG_REG_TRIM: nxt_st.rdata = st_ff.trim;
                default: nxt_st.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            st_ff <= '0;
            st_ff.mode <= MODE_SELF;
            st_ff.filter_value <= `FCG_FILT_RST;
            st_ff.trim <= `FCG_TRIM_RST;
        end else if (ce_i) begin
            st_ff <= nxt_st;
        end
    end

    assign rdata_o = st_ff.rdata;
    assign main_output_clock_o = st_ff.main_clk;
    assign loop_multiplied_clock_o = st_ff.osc_clk;
    assign ext_reference_clock_o = st_ff.ext_clk;
    assign fixed_freq_enable_o = st_ff.ffe;
    assign debug_local_clock_o = st_ff.dbg_clk;
    assign rti_clock_o = st_ff.rti_clk;
    assign osc_input_pin_en_o = st_ff.pin_en;
    assign osc_output_pin_o = st_ff.pin_out;
    assign osc_output_pin_oe_o = st_ff.pin_oe;
    assign osc_high_gain_o = st_ff.c1.high_gain_select;
    assign osc_range_o = st_ff.c1.range;
    assign reset_req_o = st_ff.reset_req;
    assign irq_req_o = st_ff.irq_req;

    AST_RESET_SELF: assert property (@(posedge clock_i)
        $rose(rst_n_i) |-> st_ff.mode == MODE_SELF && !st_ff.lock)
        else $error("not in self-clocked mode after reset");
    AST_OFF_STATIC: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        st_ff.mode == MODE_OFF && $past(st_ff.mode) == MODE_OFF |-> $stable(main_output_clock_o))
        else $error("main clock moved in off mode");
    AST_BYPASS_VALID: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        st_ff.mode == MODE_BYP_EXT && $past(st_ff.mode) != MODE_BYP_EXT
        |-> $past(st_ff.ext_ref_clock_status))
        else $error("bypass entered without valid reference");
    AST_EXT_BARRED: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        st_ff.c1_written && !st_ff.ext_rsv |-> !st_ff.c1.clock_mode_field[1])
        else $error("external mode taken after internal first write");
    AST_WRITE_ONCE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $past(st_ff.c1_written) |-> $stable(st_ff.c1.high_gain_select)
        && $stable(st_ff.c1.range) && $stable(st_ff.c1.ext_reference_select))
        else $error("write-once bit changed");
    AST_LOCK_SWITCH: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ce_i && st_ff.mode == MODE_LOOP_EXT && st_ff.lock && !st_ff.main_clk
        && !stop_i && st_ff.ext_ref_clock_status |=> !st_ff.src_ext)
        else $error("output not moved to loop clock after lock");
    AST_NO_GLITCH: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $changed(st_ff.src_ext) |-> !$past(st_ff.main_clk) && !st_ff.main_clk)
        else $error("source switched while output high");
    AST_LOSS_RESET: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $rose(st_ff.lost_clk) && $past(st_ff.c2.loc_reset_en) |-> reset_req_o)
        else $error("clock loss did not request reset");
    AST_PINS_UNUSED: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !st_ff.ext_rsv && $past(!st_ff.ext_rsv) |-> !osc_input_pin_en_o && !osc_output_pin_oe_o)
        else $error("oscillator pin used without reservation");
endmodule : fcg_clock_generator
`default_nettype wire

// [fcg_cfg.svh]
/*
 * Constants of the clock generator: register indices, field positions,
 * reset values and timing counts.
 * Assumes a 100 MHz system clock and inclusion by its bare name.
 */
`ifndef FCG_CFG_SVH
`define FCG_CFG_SVH

`define FCG_REG_CTRL1 3'h0
`define FCG_REG_CTRL2 3'h1
`define FCG_REG_STAT1 3'h2
`define FCG_REG_STAT2 3'h3
`define FCG_REG_FILT_UP 3'h4
`define FCG_REG_FILT_LO 3'h5
`define FCG_REG_TRIM 3'h6

`define FCG_C1_HIGH_GAIN 7
`define FCG_C1_RANGE 6
`define FCG_C1_REF_SEL 5
`define FCG_C1_MODE_HI 4
`define FCG_C1_MODE_LO 3
`define FCG_C1_OSC_KEEP 2
`define FCG_C1_LOC_DIS 1
`define FCG_C2_LOL_RE 7
`define FCG_C2_LOC_RE 3
`define FCG_S1_FLAG 0

`define FCG_FILT_RST 12'h0C0
`define FCG_TRIM_RST 8'h80
`define FCG_TRIM_MID 16'h0080

`define FCG_CLK_HZ 64'd100000000
`define FCG_IRC_HZ 64'd243000
`define FCG_DBG_HZ 64'd8000000
`define FCG_RTI_HZ 64'd1000000
`define FCG_ACC_ONE 64'd65536
`define FCG_LOC_NS 64'd10000
`define FCG_LOC_CYC (((`FCG_LOC_NS * (`FCG_CLK_HZ / 64'd1000000)) + 64'd999) / 64'd1000)
`define FCG_EDGES_VALID 3'h4
`define FCG_LOCK_TOL 8'h01
`define FCG_UNLOCK_TOL 8'h02

`endif

// [fcg_pkg.sv]
/*
 * Types of the clock generator: operating modes, register fields, register port.
 * Assumes fcg_cfg.svh beside it.
 */
package fcg_pkg;
    typedef enum logic [4:0] {
        MODE_OFF = 5'h01,
        MODE_SELF = 5'h02,
        MODE_LOOP_INT = 5'h04,
        MODE_BYP_EXT = 5'h08,
        MODE_LOOP_EXT = 5'h10
    } fcg_mode_e;

    typedef struct packed {
        logic high_gain_select;
        logic range;
        logic ext_reference_select;
        logic [1:0] clock_mode_field;
        logic osc_keep_on_in_off;
        logic clock_loss_detect_disable;
    } fcg_ctrl1_s;

    typedef struct packed {
        logic lol_reset_en;
        logic [2:0] mult_factor;
        logic loc_reset_en;
        logic [2:0] reduce_div;
    } fcg_ctrl2_s;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } fcg_bus_s;
endpackage : fcg_pkg

// [fcg_ext_clock.sv]
/*
 * External clock source that faces the oscillator input pin.
 * Assumes the bench clock at 100 MHz; when stopped the source stands low.
 */
`timescale 1ns/1ps
`default_nettype none
module fcg_ext_clock (
    input wire logic clock_i,
    input wire logic run_i,
    input wire logic [7:0] half_i,
    output logic pin_o
);
    logic [7:0] cnt_ff;
    always @(posedge clock_i) begin
        if (!run_i) begin
            cnt_ff <= 8'h00;
            pin_o <= 1'b0;
        end else if (cnt_ff + 8'h01 >= half_i) begin
            cnt_ff <= 8'h00;
            pin_o <= ~pin_o;
        end else begin
            cnt_ff <= cnt_ff + 8'h01;
        end
    end
endmodule : fcg_ext_clock
`default_nettype wire

// [tb_fcg_clock_generator.sv]
/*
 * Self-checking bench of the clock generator: registers, modes, loss of clock.
 * Assumes fcg_cfg.svh, the design and the external clock model beside it.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fcg_cfg.svh"
module tb_fcg_clock_generator;
    logic clock_i;
    logic rst_n_i = 1'b0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic stop_i = 1'b0;
    logic run = 1'b0;
    logic ce = 1'b1;
    logic [2:0] addr_i = 3'h0;
    logic [7:0] wdata_i = 8'h00;
    logic [7:0] rdata_o, v, r;
    logic pin, mclk, lclk, eclk, ffe, dclk, rclk, pin_en, opin, opin_oe, hg, rg, rreq, irq;
    int failures = 0;
    int check_count = 0;
    int nd, nr, nm, nl;
    int nrst = 0;
    logic [31:0] seed = 32'hFB063936;

    fcg_clock_generator dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .stop_i(stop_i),
        .osc_input_pin_i(pin), .rdata_o(rdata_o), .main_output_clock_o(mclk),
        .loop_multiplied_clock_o(lclk), .ext_reference_clock_o(eclk),
        .fixed_freq_enable_o(ffe), .debug_local_clock_o(dclk), .rti_clock_o(rclk),
        .osc_input_pin_en_o(pin_en), .osc_output_pin_o(opin),
        .osc_output_pin_oe_o(opin_oe), .osc_high_gain_o(hg), .osc_range_o(rg),
        .reset_req_o(rreq), .irq_req_o(irq));
    fcg_ext_clock ext_u (.clock_i(clock_i), .run_i(run), .half_i(8'd50), .pin_o(pin));

    // counts reset request pulses, sampled mid-cycle where they are settled
    always @(negedge clock_i) nrst += int'(rreq === 1'b1);

    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : rnd

    function automatic logic [7:0] c1(input logic g, n, f, input logic [1:0] m);
        return {g, n, f, m, 3'b000};
    endfunction : c1

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask : rd

    task automatic do_reset();
        @(posedge clock_i);
        rst_n_i <= 1'b0;
        repeat (10) @(posedge clock_i);
        rst_n_i <= 1'b1;
    endtask : do_reset

    // polls status one until the masked bits match, within n reads
    task automatic wait_bits(input logic [7:0] m, input logic [7:0] w, input int n);
        logic [7:0] s;
        for (int i = 0; i < n; i++) begin
            rd(`FCG_REG_STAT1, s);
            if ((s & m) === w) break;
        end
        chk(s & m, w);
    endtask : wait_bits

    task automatic toggles(input int n);
        logic pd, pr, pm, pl;
        nd = 0;
        nr = 0;
        nm = 0;
        nl = 0;
        @(posedge clock_i) #1;
        {pd, pr, pm, pl} = {dclk, rclk, mclk, lclk};
        repeat (n) begin
            @(posedge clock_i) #1;
            nd += int'(dclk !== pd);
            nr += int'(rclk !== pr);
            nm += int'(mclk !== pm);
            nl += int'(lclk !== pl);
            {pd, pr, pm, pl} = {dclk, rclk, mclk, lclk};
        end
    endtask : toggles

    task automatic summarize();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize

    initial begin
        #900000;
        failures++;
        summarize();
    end

    initial begin
        do_reset();
        rd(`FCG_REG_CTRL1, v);
        chk(v & 8'h18, 8'h00);
        rd(`FCG_REG_FILT_UP, v);
        chk(v, 8'h00);
        rd(`FCG_REG_FILT_LO, v);
        chk(v, 8'hC0);
        rd(`FCG_REG_TRIM, v);
        chk(v, 8'h80);
        rd(3'h7, v);
        chk(v, 8'h00);
        r = rnd();
        wr(`FCG_REG_FILT_LO, r);
        rd(`FCG_REG_FILT_LO, v);
        chk(v, r);
        r = rnd();
        wr(`FCG_REG_TRIM, r);
        rd(`FCG_REG_TRIM, v);
        chk(v, r);
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            r[2:0] = i[2:0];
            wr(`FCG_REG_CTRL2, r);
            rd(`FCG_REG_CTRL2, v);
            chk(v, r);
        end
        // known divider, trim and filter so the loop tests can lock in time
        wr(`FCG_REG_CTRL2, 8'h00);
        wr(`FCG_REG_TRIM, `FCG_TRIM_RST);
        wr(`FCG_REG_FILT_UP, 8'h02);
        wr(`FCG_REG_FILT_LO, 8'h80);
        toggles(1000);
        chk(8'(nd >= 140 && nd <= 180), 8'h01);
        chk(8'(nr >= 15 && nr <= 25), 8'h01);
        chk(8'(nm > 0), 8'h01);
        chk(8'(nl > 0), 8'h01);
        ce <= 1'b0;
        toggles(100);
        chk(8'(nd + nr + nm + nl), 8'h00);
        ce <= 1'b1;
        $display("test reset_and_registers done");

        wr(`FCG_REG_CTRL1, c1(1'b1, 1'b1, 1'b0, 2'b01));
        repeat (2) @(posedge clock_i);
        chk({4'h0, hg, rg, pin_en, opin_oe}, 8'h0C);
        wr(`FCG_REG_CTRL1, c1(1'b0, 1'b0, 1'b1, 2'b11));
        rd(`FCG_REG_CTRL1, v);
        chk(v & 8'hF8, c1(1'b1, 1'b1, 1'b0, 2'b01));
        wait_bits(8'hC8, 8'h48, 1500);
        stop_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        toggles(100);
        chk(8'(nm), 8'h00);
        stop_i <= 1'b0;
        $display("test internal_loop done");

        do_reset();
        run <= 1'b1;
        wr(`FCG_REG_CTRL1, c1(1'b0, 1'b1, 1'b0, 2'b10));
        rd(`FCG_REG_STAT1, v);
        chk(v & 8'hC2, 8'h00);
        chk({6'h0, pin_en, opin_oe}, 8'h02);
        wait_bits(8'hC2, 8'h82, 1000);
        chk({7'h0, ffe}, 8'h01);
        run <= 1'b0;
        wait_bits(8'h06, 8'h04, 1000);
        rd(`FCG_REG_STAT1, v);
        chk(v & 8'hC1, 8'h01);
        repeat (2) @(posedge clock_i);
        chk({7'h0, irq}, 8'h01);
        wr(`FCG_REG_STAT1, 8'h01);
        repeat (2) @(posedge clock_i);
        chk({7'h0, irq}, 8'h00);
        wr(`FCG_REG_CTRL2, 8'h08);
        run <= 1'b1;
        wait_bits(8'h02, 8'h02, 1000);
        run <= 1'b0;
        wait_bits(8'h07, 8'h04, 1000);
        chk(8'(nrst), 8'h01);
        $display("test bypass_and_loss done");

        do_reset();
        run <= 1'b1;
        wr(`FCG_REG_FILT_UP, 8'h0A);
        wr(`FCG_REG_FILT_LO, 8'h40);
        wr(`FCG_REG_CTRL1, c1(1'b1, 1'b0, 1'b1, 2'b11));
        wait_bits(8'hCA, 8'hCA, 4000);
        chk({7'h0, opin_oe}, 8'h01);
        $display("test external_loop done");
        summarize();
    end
endmodule : tb_fcg_clock_generator
`default_nettype wire
